// ### logic/swp_defines.vh
// constants for the single-wire programming slave
`ifndef SWP_DEFINES_VH
`define SWP_DEFINES_VH
// timing figures, microseconds unless noted
`define SWP_CLK_MHZ 10
`define SWP_TURN_ON_MS 5
`define SWP_ENTRY_MIN_MS 20
`define SWP_ENTRY_MAX_MS 30
`define SWP_TIMEOUT_US 220
`define SWP_START_LOW_US 5
`define SWP_STOP_HIGH_US 5
`define SWP_BIT_MIN_US 10
`define SWP_BIT_MAX_US 100
`define SWP_TKO_SLV_US 3
`define SWP_PUMP_SETTLE_MS 1
// derived cycle counts
`define SWP_TURN_ON_CYC (`SWP_TURN_ON_MS * 1000 * `SWP_CLK_MHZ)
`define SWP_ENTRY_CYC (`SWP_ENTRY_MIN_MS * 1000 * `SWP_CLK_MHZ)
`define SWP_TIMEOUT_CYC (`SWP_TIMEOUT_US * `SWP_CLK_MHZ)
`define SWP_START_LOW_CYC (`SWP_START_LOW_US * `SWP_CLK_MHZ)
`define SWP_STOP_HIGH_CYC (`SWP_STOP_HIGH_US * `SWP_CLK_MHZ)
`define SWP_TKO_SLV_CYC (`SWP_TKO_SLV_US * `SWP_CLK_MHZ)
`define SWP_PUMP_SETTLE_CYC (`SWP_PUMP_SETTLE_MS * 1000 * `SWP_CLK_MHZ)
// command byte fields
`define SWP_REGION_HI 7
`define SWP_REGION_LO 5
`define SWP_ADDR_HI 4
`define SWP_ADDR_LO 1
`define SWP_DIR_BIT 0
`define SWP_REGION_NVM 3'h0
`define SWP_REGION_REG 3'h4
// register space addresses
`define SWP_ADDR_CTRL 4'h0
`define SWP_ADDR_TESTCTRL 4'h1
`define SWP_ADDR_SIGNATURE 4'h2
// control register bits
`define SWP_CTRL_PUMP_BIT 0
`define SWP_CTRL_WREN_BIT 1
`endif

// ### logic/swp_fifo.v
// small valid/ready fifo for received write words
`timescale 1ns/10ps
module swp_fifo #(
  parameter WIDTH = 20,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wr_reg;
  reg [AW-1:0] rd_reg;
  reg [AW:0] cnt_reg;
  wire push;
  wire pop;
  assign in_ready = (cnt_reg != DEPTH[AW:0]);
  assign out_valid = (cnt_reg != {(AW+1){1'b0}});
  assign out_data = mem_reg[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always @(posedge clk)
  begin
    if (push)
      mem_reg[wr_reg] <= in_data;
    if (rst)
    begin
      wr_reg <= {AW{1'b0}};
      rd_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_reg <= (wr_reg == DEPTH-1) ? {AW{1'b0}} : wr_reg + 1'b1;
      if (pop)
        rd_reg <= (rd_reg == DEPTH-1) ? {AW{1'b0}} : rd_reg + 1'b1;
      if (push && !pop)
        cnt_reg <= cnt_reg + 1'b1;
      else if (pop && !push)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end
endmodule

// ### logic/swp_slave.v
// one channel of the single-wire programming slave
`timescale 1ns/10ps
`include "swp_defines.vh"
// Function
// - after reset and turn-on time, pin runs as analog output from stored data.
// - command mode only via entry write inside the entry window after reset.
// - pin is the bidirectional link; slave never starts a transfer.
// - frame starts at a rising edge after low held at least start time.
// - one command byte then the data phase immediately.
// - reads carry a handover bit before and after the data.
// - exactly two data bytes form one 16-bit word.
// - high for the stop time after last rising edge ends the transfer.
// - no rising edge for time-out period abandons the frame to idle.
// - long high pulse means one, short high pulse means zero.
// - most significant byte first, most significant bit first.
// - command byte: region 7..5, address 4..1, direction bit 0.
// - region 000 is memory, 100 is register space, others reserved.
// - command mode gives access to memory, control, test-control, signature.
// - command mode is left only by power-on reset.
// - memory stored only after pump enabled and settle time elapsed.
// - communication reset no later than 220 us after last rising edge.
// - bit period between 10 and 100 us.
// - entry window spans 20 to 30 ms after power-on; the code opens it at reset and closes it at ENTRY_CYC (20 ms).
module swp_slave #(
  parameter TURN_ON_CYC = `SWP_TURN_ON_CYC,
  parameter ENTRY_CYC = `SWP_ENTRY_CYC,
  parameter PUMP_CYC = `SWP_PUMP_SETTLE_CYC,
  parameter [15:0] SIGNATURE = 16'h5A3C
) (
  input wire clk,
  input wire rst,
  input wire link_in,
  output reg link_out,
  output reg link_oe,
  output reg analog_en,
  output reg cmd_mode,
  output reg nvm_we,
  output reg [3:0] nvm_addr,
  output reg [15:0] nvm_wdata,
  input wire [15:0] nvm_rdata,
  output reg [15:0] control_register,
  output reg [15:0] test_control_register,
  output reg frame_error
);
  // signature value is arbitrary
  localparam S_IDLE = 3'h0;
  localparam S_CMD = 3'h1;
  localparam S_HAND = 3'h2;
  localparam S_TX = 3'h3;
  localparam S_DATA = 3'h4;
  localparam S_TKOV = 3'h5;
  localparam [17:0] TO_CYC = `SWP_TIMEOUT_CYC;
  localparam [17:0] START_CYC = `SWP_START_LOW_CYC;
  localparam [17:0] STOP_CYC = `SWP_STOP_HIGH_CYC;
  localparam [17:0] TKO_CYC = `SWP_TKO_SLV_CYC;
  // ============================================================
  // power-on timing and modes
  reg [27:0] por_cnt_reg;
  reg [27:0] pump_cnt_reg;
  reg pump_ready_reg;
  wire window_open;
  assign window_open = (por_cnt_reg < ENTRY_CYC);
  // ============================================================
  // edge and width measurement
  reg link_d_reg;
  reg [17:0] low_cnt_reg;
  reg [17:0] high_cnt_reg;
  reg [17:0] since_rise_reg;
  reg [17:0] period_reg;
  reg [17:0] hi_width_reg;
  reg [2:0] state_reg;
  reg [4:0] bit_cnt_reg;
  reg [7:0] cmd_reg;
  reg [15:0] shift_reg;
  reg [17:0] tx_cnt_reg;
  reg first_rise_reg;
  reg word_done_reg;
  wire rise;
  wire fall;
  wire rx_bit;
  wire [2:0] region;
  wire valid_region;
  assign rise = link_in && !link_d_reg;
  assign fall = !link_in && link_d_reg;
  // high width of the finished bit compared with half a period; the first bit has no
  // earlier period, later ones use the previous bit since a stop stretches the last low
  assign rx_bit = first_rise_reg ? ({hi_width_reg, 1'b0} > {1'b0, low_cnt_reg + hi_width_reg}) :
    ({hi_width_reg, 1'b0} > {1'b0, period_reg});
  assign region = cmd_reg[`SWP_REGION_HI:`SWP_REGION_LO];
  assign valid_region = (region == `SWP_REGION_NVM) || (region == `SWP_REGION_REG);
  // ============================================================
  // write words pass a fifo so an nvm busy cycle does not lose them
  wire [19:0] fifo_out;
  wire fifo_out_valid;
  wire fifo_in_ready;
  reg fifo_push_reg;
  reg [19:0] fifo_in_reg;
  swp_fifo #(.WIDTH(20), .DEPTH(4), .AW(2)) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_data(fifo_in_reg),
    .in_valid(fifo_push_reg),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(1'b1)
  );
  // ============================================================
  // link receiver and transmitter
  always @(posedge clk)
  begin
    if (rst)
    begin
      link_d_reg <= 1'b1;
      low_cnt_reg <= 18'h0;
      high_cnt_reg <= 18'h0;
      since_rise_reg <= 18'h0;
      period_reg <= 18'h0;
      hi_width_reg <= 18'h0;
      state_reg <= S_IDLE;
      bit_cnt_reg <= 5'h0;
      cmd_reg <= 8'h0;
      shift_reg <= 16'h0;
      tx_cnt_reg <= 18'h0;
      first_rise_reg <= 1'b0;
      word_done_reg <= 1'b0;
      link_out <= 1'b0;
      link_oe <= 1'b0;
      fifo_push_reg <= 1'b0;
      fifo_in_reg <= 20'h0;
      frame_error <= 1'b0;
    end
    else
    begin
      link_d_reg <= link_in;
      fifo_push_reg <= 1'b0;
      if (rise)
        since_rise_reg <= 18'h0;
      else if (since_rise_reg != 18'h3FFFF)
        since_rise_reg <= since_rise_reg + 18'h1;
      if (fall)
      begin
        hi_width_reg <= high_cnt_reg;
        low_cnt_reg <= 18'h0;
      end
      else if (!link_in && low_cnt_reg != 18'h3FFFF)
        low_cnt_reg <= low_cnt_reg + 18'h1;
      if (rise)
        high_cnt_reg <= 18'h0;
      else if (link_in && high_cnt_reg != 18'h3FFFF)
        high_cnt_reg <= high_cnt_reg + 18'h1;
      if (state_reg != S_IDLE && state_reg != S_TX && since_rise_reg >= TO_CYC)
      begin
        state_reg <= S_IDLE;
        frame_error <= 1'b1;
        link_oe <= 1'b0;
      end
      else
        case (state_reg)
          S_IDLE:
          begin
            link_oe <= 1'b0;
            // slave only listens here; it never opens a frame
            if (rise && low_cnt_reg >= START_CYC && analog_en == 1'b0 || rise && window_open
                && low_cnt_reg >= START_CYC)
            begin
              state_reg <= S_CMD;
              bit_cnt_reg <= 5'h0;
              first_rise_reg <= 1'b1;
              word_done_reg <= 1'b0;
              frame_error <= 1'b0;
            end
          end
          S_CMD, S_DATA:
          begin
            // a bit ends at the next rising edge, which also sets the period
            if (rise)
            begin
              first_rise_reg <= 1'b0;
              if (state_reg == S_CMD)
              begin
                cmd_reg <= {cmd_reg[6:0], rx_bit};
                bit_cnt_reg <= bit_cnt_reg + 5'h1;
                if (bit_cnt_reg == 5'h7)
                begin
                  bit_cnt_reg <= 5'h0;
                  if (cmd_reg[6] == 1'b1 || rx_bit)
                    state_reg <= S_CMD;
                  if (rx_bit)
                    state_reg <= S_HAND;
                  else
                    state_reg <= S_DATA;
                end
              end
              else if (!word_done_reg)
              begin
                shift_reg <= {shift_reg[14:0], rx_bit};
                bit_cnt_reg <= bit_cnt_reg + 5'h1;
                if (bit_cnt_reg == 5'hF)
                begin
                  word_done_reg <= 1'b1;
                  if (valid_region && fifo_in_ready)
                  begin
                    fifo_in_reg <= {cmd_reg[`SWP_ADDR_HI:`SWP_ADDR_LO], shift_reg[14:0], rx_bit};
                    fifo_push_reg <= 1'b1;
                  end
                end
              end
              period_reg <= low_cnt_reg + hi_width_reg;
            end
            // long high after the last edge closes the frame; a long one bit is not a stop
            if (link_in && high_cnt_reg >= STOP_CYC && !first_rise_reg
                && word_done_reg)
              state_reg <= S_IDLE;
          end
          S_HAND:
          begin
            // master handover bit: for a valid region the slave drives low after its falling edge
            if (fall)
            begin
              state_reg <= S_TX;
              tx_cnt_reg <= 18'h0;
              bit_cnt_reg <= 5'h0;
              shift_reg <= (region == `SWP_REGION_NVM) ? nvm_rdata :
                (cmd_reg[`SWP_ADDR_HI:`SWP_ADDR_LO] == `SWP_ADDR_CTRL) ? control_register :
                (cmd_reg[`SWP_ADDR_HI:`SWP_ADDR_LO] == `SWP_ADDR_TESTCTRL) ?
                test_control_register : SIGNATURE;
              link_out <= 1'b0;
              link_oe <= valid_region;
            end
          end
          S_TX:
          begin
            // slave sends 16 data bits then a one handover bit; high phase first after the takeover low
            tx_cnt_reg <= tx_cnt_reg + 18'h1;
            if (bit_cnt_reg == 5'h0 && tx_cnt_reg < TKO_CYC)
              link_out <= 1'b0;
            else
            begin
              if (tx_cnt_reg == TKO_CYC && bit_cnt_reg == 5'h0)
              begin
                tx_cnt_reg <= 18'h0;
                bit_cnt_reg <= 5'h1;
              end
              else if (tx_cnt_reg == period_reg)
              begin
                tx_cnt_reg <= 18'h0;
                bit_cnt_reg <= bit_cnt_reg + 5'h1;
                if (bit_cnt_reg <= 5'h10)
                  shift_reg <= {shift_reg[14:0], 1'b0};
                if (bit_cnt_reg == 5'h11)
                begin
                  state_reg <= S_TKOV;
                  link_oe <= 1'b0;
                end
              end
              if (bit_cnt_reg <= 5'h10)
                link_out <= (tx_cnt_reg < (shift_reg[15] ? (period_reg - (period_reg >> 2)) :
                  (period_reg >> 2)));
              else
                link_out <= (tx_cnt_reg < (period_reg - (period_reg >> 2)));
            end
          end
          S_TKOV:
          begin
            // bus released; master takes over and stops, or time-out idles
            link_oe <= 1'b0;
            if (link_in && high_cnt_reg >= STOP_CYC)
              state_reg <= S_IDLE;
          end
          default:
            state_reg <= S_IDLE;
        endcase
    end
  end
  // ============================================================
  // mode control and register space
  always @(posedge clk)
  begin
    if (rst)
    begin
      por_cnt_reg <= 28'h0;
      analog_en <= 1'b0;
      cmd_mode <= 1'b0;
      control_register <= 16'h0;
      test_control_register <= 16'h0;
      pump_cnt_reg <= 28'h0;
      pump_ready_reg <= 1'b0;
      nvm_we <= 1'b0;
      nvm_addr <= 4'h0;
      nvm_wdata <= 16'h0;
    end
    else
    begin
      nvm_we <= 1'b0;
      if (por_cnt_reg != 28'hFFFFFFF)
        por_cnt_reg <= por_cnt_reg + 28'h1;
      if (por_cnt_reg >= TURN_ON_CYC && !cmd_mode)
        analog_en <= 1'b1;
      if (control_register[`SWP_CTRL_PUMP_BIT] && control_register[`SWP_CTRL_WREN_BIT])
      begin
        if (pump_cnt_reg >= PUMP_CYC)
          pump_ready_reg <= 1'b1;
        else
          pump_cnt_reg <= pump_cnt_reg + 28'h1;
      end
      else
      begin
        pump_cnt_reg <= 28'h0;
        pump_ready_reg <= 1'b0;
      end
      if (fifo_out_valid)
      begin
        if (!cmd_mode)
        begin
          // entry word must hit the signature register inside the window
          if (window_open && fifo_out[19:16] == `SWP_ADDR_SIGNATURE
              && fifo_out[15:0] == SIGNATURE && region == `SWP_REGION_REG)
          begin
            cmd_mode <= 1'b1;
            analog_en <= 1'b0;
          end
        end
        else if (region == `SWP_REGION_NVM)
        begin
          nvm_addr <= fifo_out[19:16];
          nvm_wdata <= fifo_out[15:0];
          nvm_we <= pump_ready_reg;
        end
        else if (fifo_out[19:16] == `SWP_ADDR_CTRL)
          control_register <= fifo_out[15:0];
        else if (fifo_out[19:16] == `SWP_ADDR_TESTCTRL)
          test_control_register <= fifo_out[15:0];
      end
    end
  end
endmodule

// ### testbench/swp_slave_monitor.sv
// assertion checker for the single-wire programming slave
`timescale 1ns/10ps
module swp_slave_monitor #(
  parameter TURN_ON_CYC = 100
) (
  input wire clk,
  input wire rst,
  input wire link_in,
  input wire link_out,
  input wire link_oe,
  input wire analog_en,
  input wire cmd_mode,
  input wire nvm_we,
  input wire [15:0] control_register,
  input wire frame_error
);
  // ==========================================
  // helper counters
  reg [31:0] por_cnt;
  reg [15:0] gap_cnt;
  reg link_d;
  always @(posedge clk)
  begin
    if (rst)
    begin
      por_cnt <= 32'h0;
      gap_cnt <= 16'h0;
      link_d <= 1'b1;
    end
    else
    begin
      // saturate so a long run never wraps into a false turn-on match
      if (por_cnt != 32'hFFFFFFFF)
        por_cnt <= por_cnt + 32'h1;
      link_d <= link_in;
      if (link_in && !link_d)
        gap_cnt <= 16'h0;
      else if (gap_cnt != 16'hFFFF)
        gap_cnt <= gap_cnt + 16'h1;
    end
  end
  // ==========================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_takeover_low;
    !link_out [*8];
  endsequence
  sequence s_pulse_end;
    ##1 !nvm_we;
  endsequence
  a_oe_cmd_only: assert property (link_oe |-> cmd_mode)
    else $error("pin driven outside command mode");
  a_cmd_sticky: assert property (cmd_mode |=> cmd_mode)
    else $error("command mode left");
  a_analog_off: assert property (cmd_mode |-> !analog_en)
    else $error("analog output on in command mode");
  a_turn_on_time: assert property ($rose(analog_en) |->
    por_cnt >= TURN_ON_CYC - 2 && por_cnt <= TURN_ON_CYC + 2)
    else $error("analog output turn-on time wrong");
  a_handover_fall: assert property ($rose(link_oe) |-> !$past(link_in))
    else $error("slave drive not after handover fall");
  a_takeover_low: assert property ($rose(link_oe) |-> s_takeover_low)
    else $error("slave takeover low too short");
  a_we_pulse: assert property (nvm_we |-> s_pulse_end)
    else $error("memory write strobe longer than one cycle");
  a_we_pump: assert property (nvm_we |-> cmd_mode && control_register[0]
    && control_register[1])
    else $error("memory write without pump enabled");
  a_ctrl_update: assert property ($changed(control_register) && !$past(rst) |->
    $past(cmd_mode) && link_in && !link_oe)
    else $error("control changed outside a closed frame");
  a_timeout_bound: assert property ($rose(frame_error) |->
    gap_cnt >= 16'h088E && gap_cnt <= 16'h08A2)
    else $error("time-out not at its period");
endmodule
bind swp_slave swp_slave_monitor #(.TURN_ON_CYC(TURN_ON_CYC)) i_mon (.clk(clk), .rst(rst),
  .link_in(link_in), .link_out(link_out), .link_oe(link_oe), .analog_en(analog_en),
  .cmd_mode(cmd_mode), .nvm_we(nvm_we), .control_register(control_register),
  .frame_error(frame_error));

// ### testbench/swp_master_model.sv
// programming master model on the shared pin
`timescale 1ns/10ps
module swp_master_model #(
  parameter TB = 120
) (
  input wire clk,
  input wire s_out,
  input wire s_oe,
  output wire line
);
  reg m_out = 1'b1;
  reg m_oe = 1'b1;
  // pull-up on the pin; both low during a takeover overlap is legal
  assign line = (m_oe ? m_out : 1'b1) & (s_oe ? s_out : 1'b1);
  task drive(input v, input integer n);
    begin
      m_out = v;
      repeat (n) @(negedge clk);
    end
  endtask
  task send_bit(input b);
    begin
      drive(1'b1, b ? TB * 3 / 4 : TB / 4);
      drive(1'b0, b ? TB / 4 : TB * 3 / 4);
    end
  endtask
  task send_byte(input [7:0] b);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1)
        send_bit(b[i]);
    end
  endtask
  task start_cmd(input [7:0] cmd);
    begin
      m_oe = 1'b1;
      drive(1'b0, 60);
      send_byte(cmd);
    end
  endtask
  task stop_frame;
    begin
      m_oe = 1'b1;
      drive(1'b0, 60);
      drive(1'b1, 80);
    end
  endtask
  task write_frame(input [7:0] cmd, input [15:0] d);
    begin
      start_cmd(cmd);
      send_byte(d[15:8]);
      send_byte(d[7:0]);
      stop_frame;
    end
  endtask
  task read_frame(input [7:0] cmd, output [15:0] d, output ok);
    integer i;
    integer n;
    integer h;
    begin
      ok = 1'b1;
      d = 16'h0000;
      start_cmd(cmd);
      drive(1'b1, TB / 4);
      drive(1'b0, TB / 2);
      m_oe = 1'b0;
      // bounded waits: a silent slave leaves the pin pulled high
      for (i = 15; i >= -1 && ok; i = i - 1)
      begin
        n = 0;
        h = 0;
        while (line !== 1'b1 && n < 3000)
        begin
          @(negedge clk);
          n = n + 1;
        end
        while (line === 1'b1 && h < 3000)
        begin
          @(negedge clk);
          h = h + 1;
        end
        if (h >= 3000 || n >= 3000)
          ok = 1'b0;
        if (i >= 0)
          d[i] = (h > TB / 2);
      end
      m_out = ok ? 1'b0 : 1'b1;
      m_oe = 1'b1;
      if (ok)
        stop_frame;
    end
  endtask
  task abort_frame;
    begin
      m_oe = 1'b1;
      drive(1'b0, 60);
      send_bit(1'b1);
      send_bit(1'b0);
      drive(1'b0, 2400);
    end
  endtask
endmodule

// ### testbench/tb_swp_slave.sv
// self-checking bench for the single-wire programming slave
`timescale 1ns/10ps
module tb_swp_slave;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [15:0] nvm_rdata = 16'h0000;
  wire line, link_out, link_oe, analog_en, cmd_mode, nvm_we, frame_error;
  wire [3:0] nvm_addr;
  wire [15:0] nvm_wdata, control_register, test_control_register;
  integer errors = 0;
  integer num_checks = 0;
  integer nwe = 0;
  integer seed, r;
  reg [15:0] v, w, rd, we_d;
  reg [3:0] a, we_a;
  reg ok;
  always #50 clk = ~clk;
  swp_master_model #(.TB(120)) i_m (.clk(clk), .s_out(link_out), .s_oe(link_oe), .line(line));
  swp_slave #(.TURN_ON_CYC(100), .ENTRY_CYC(20000), .PUMP_CYC(8000),
    .SIGNATURE(16'hA55A)) i_dut (.clk(clk), .rst(rst), .link_in(line), // arbitrary
    .link_out(link_out), .link_oe(link_oe), .analog_en(analog_en), .cmd_mode(cmd_mode),
    .nvm_we(nvm_we), .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata),
    .control_register(control_register), .test_control_register(test_control_register),
    .frame_error(frame_error));
  always @(posedge clk)
    if (nvm_we === 1'b1)
    begin
      nwe = nwe + 1;
      we_a = nvm_addr;
      we_d = nvm_wdata;
    end
  task check(input [15:0] got, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
        errors = errors + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task tend(input [8*8-1:0] s);
    $display("test %0s done", s);
  endtask
  task end_sim;
    begin
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial
  begin
    repeat (90000) @(posedge clk);
    errors = errors + 1;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim;
  end
  initial
  begin
    seed = 32'h8288;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    check(link_oe, 1'b0);
    repeat (90) @(negedge clk);
    check(analog_en, 1'b0);
    repeat (20) @(negedge clk);
    check(analog_en, 1'b1);
    tend("turnon");
    i_m.write_frame(8'h80, 16'h1234);
    check(control_register, 16'h0000);
    check(cmd_mode, 1'b0);
    i_m.write_frame(8'h84, 16'hA55A);
    check(cmd_mode, 1'b1);
    check(analog_en, 1'b0);
    tend("entry");
    v = $random(seed) & 16'hFFFC;
    i_m.write_frame(8'h80, v);
    check(control_register, v);
    w = $random(seed);
    i_m.write_frame(8'h82, w);
    check(test_control_register, w);
    for (r = 1; r < 8; r = r + 1)
      if (r != 4)
      begin
        i_m.write_frame({r[2:0], 4'h0, 1'b0}, $random(seed));
        check(control_register, v);
      end
    tend("regs");
    i_m.write_frame(8'h80, 16'h0003);
    a = $random(seed);
    w = $random(seed);
    i_m.write_frame({3'h0, a, 1'b0}, w);
    check(nwe, 0);
    repeat (8000) @(negedge clk);
    i_m.write_frame({3'h0, a, 1'b0}, w);
    check(nwe, 1);
    check(we_a, a);
    check(we_d, w);
    i_m.write_frame(8'h1E, ~w);
    check(nwe, 2);
    check(we_a, 4'hF);
    tend("nvm");
    i_m.read_frame(8'h81, rd, ok);
    check(ok, 1'b1);
    check(rd, 16'h0003);
    nvm_rdata = $random(seed);
    i_m.read_frame({3'h0, a, 1'b1}, rd, ok);
    check(rd, nvm_rdata);
    i_m.read_frame(8'h41, rd, ok);
    check(ok, 1'b0);
    tend("read");
    v = $random(seed) & 16'hFFFC;
    i_m.write_frame(8'h80, v);
    check(frame_error, 1'b0);
    i_m.abort_frame;
    check(frame_error, 1'b1);
    i_m.write_frame(8'h82, v);
    check(test_control_register, v);
    check(cmd_mode, 1'b1);
    tend("timeout");
    end_sim;
  end
endmodule
